/* File: src/i2c_error_arbitration.v */
// two-wire bus interface: byte engine, bus error recovery, repeated start and arbitration
// assumes: APB master on pclk, open-drain pads outside, scl/sda pulled high when released
// Notes on behaviour
// - status reads 0xf8 whenever the job-done flag is clear
// - START or STOP inside a byte or acknowledge bit reports status 0x00
// - a bus error sets the job-done flag
// - recovery enters not-addressed slave and clears only the stop request
// - recovery releases both lines and sends no STOP
// - while 0xf8 is shown the engine keeps waiting or transferring by itself
// - a repeated START changes direction and keeps bus ownership
// - a master sending one while the line reads zero loses arbitration
// - identical traffic from several masters never flags a loss
// - after direction/data loss go unaddressed or wait free bus and restart
// - after address loss switch to slave and check own address
// - addressed after loss enters slave receive or transmit by direction bit
// - one master continues; the losing master keeps the received byte only after a loss in the address byte or at a byte's last bit
// - while job-done is set after a START or a byte the clock line is held low; after an unaddressed arbitration loss, a slave NACK or a STOP it is released
// - software finishes register accesses before clearing job-done
`timescale 1ns/10ps
`include "i2c_err_arb_defs.vh"
module i2c_error_arbitration (
	// apb slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// bus lines
	input wire scl_in,
	input wire sda_in,
	output wire scl_out,
	output wire scl_oe,
	output wire sda_out,
	output wire sda_oe,
	// interrupt
	output wire irq
);
	localparam S_IDLE = 4'h0;
	localparam S_START = 4'h1;
	localparam S_HOLD = 4'h2;
	localparam S_LO = 4'h3;
	localparam S_HI = 4'h4;
	localparam S_STOP1 = 4'h5;
	localparam S_STOP2 = 4'h6;
	localparam S_RS1 = 4'h7;
	localparam S_RS2 = 4'h8;
	reg [31:0] prdata_q;
	reg pready_q, pslverr_q, irq_q, scl_oe_q, sda_oe_q, zero_q;
	reg [7:0] stat_q, data_q, div_q, cnt_q, sh_q;
	reg [6:0] own_q;
	reg done_q, acken_q, sta_q, sto_q, wcol_q, en_q, tick_q;
	reg [`IRQ_W-1:0] ist_q, ien_q, ev_q;
	reg [3:0] st_q, bcnt_q;
	reg mst_q, act_q, first_q, txb_q, dir_q, arbl_q, berr_q, rs_q, busy_q, match_q, ackg_q, ph_q;
	reg [31:0] rd_d;
	reg unmap_d;
	wire scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
	wire acc = psel & penable;
	wire wr = acc & pwrite & pready_q;
	wire go = wr && (paddr == `OFS_CTRL) && pwdata[`B_DONE] && done_q;
	wire gen = (st_q == S_START) || (st_q == S_STOP1) || (st_q == S_STOP2) || (st_q == S_RS1) || (st_q == S_RS2);
	wire samp = (mst_q && (st_q == S_HI) && tick_q && scl_s) || (!mst_q && act_q && scl_rise);
	wire drive = !mst_q && act_q && scl_fall;
	wire drv_bit = (bcnt_q < `BIT_ACK) ? (txb_q & ~sh_q[7]) : (~txb_q & ackg_q);
	wire [7:0] sh_n = {sh_q[6:0], sda_s};
	wire ack = ~sda_s;
	wire [7:0] lim = (div_q < `DIV_MIN) ? `DIV_MIN : div_q;
	wire legal = (bcnt_q == `BIT_FIRST) && !mst_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign scl_out = zero_q;
	assign sda_out = zero_q;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;
	assign irq = irq_q;
	// ----------------------------------------
	// line synchronisers
	// ----------------------------------------
	bus_line_monitor u_mon (
		.pclk(pclk),
		.presetn(presetn),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det)
	);
	// ----------------------------------------
	// apb read path
	// ----------------------------------------
	always @* begin
		rd_d = 32'h0;
		unmap_d = 1'b0;
		case (paddr)
			`OFS_CTRL: rd_d[7:0] = {done_q, acken_q, sta_q, sto_q, wcol_q, en_q, 2'b00};
			`OFS_STAT: rd_d[7:0] = done_q ? stat_q : `ST_NOINFO;
			`OFS_DATA: rd_d[7:0] = data_q;
			`OFS_ADDR: rd_d[7:0] = {own_q, 1'b0};
			`OFS_DIV: rd_d[7:0] = div_q;
			`OFS_IST: rd_d[`IRQ_W-1:0] = ist_q;
			`OFS_IEN: rd_d[`IRQ_W-1:0] = ien_q;
			`OFS_ICLR: rd_d = 32'h0;
			default: unmap_d = 1'b1;
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else if (acc && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= unmap_d;
			prdata_q <= pwrite ? 32'h0 : rd_d;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end
	// ----------------------------------------
	// bit-rate tick and interrupt
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
			tick_q <= 1'b0;
			ist_q <= {`IRQ_W{1'b0}};
			irq_q <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			zero_q <= 1'b0;
			tick_q <= (cnt_q >= lim);
			cnt_q <= (cnt_q >= lim) ? 8'h00 : cnt_q + 8'h01;
			if (wr && (paddr == `OFS_ICLR))
				ist_q <= (ist_q & ~pwdata[`IRQ_W-1:0]) | ev_q;
			else
				ist_q <= ist_q | ev_q;
			irq_q <= |(ist_q & ien_q);
		end
	end
	// ----------------------------------------
	// registers and byte engine
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= `ST_NOINFO;
			data_q <= 8'h00;
			div_q <= `DIV_RST;
			own_q <= `OWN_RST;
			sh_q <= 8'h00;
			{done_q, acken_q, sta_q, sto_q, wcol_q, en_q} <= 6'h00;
			ien_q <= {`IRQ_W{1'b0}};
			ev_q <= {`IRQ_W{1'b0}};
			st_q <= S_IDLE;
			bcnt_q <= 4'h0;
			{mst_q, act_q, first_q, txb_q, dir_q, arbl_q} <= 6'h00;
			{berr_q, rs_q, busy_q, match_q, ackg_q, ph_q} <= 6'h00;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			ev_q <= {`IRQ_W{1'b0}};
			if (wr) begin
				case (paddr)
					`OFS_CTRL: begin
						acken_q <= pwdata[`B_ACKEN];
						sta_q <= pwdata[`B_STA];
						sto_q <= pwdata[`B_STO];
						en_q <= pwdata[`B_EN];
						if (pwdata[`B_DONE] && (pwdata[`B_STO] || !berr_q))
							done_q <= 1'b0;
					end
					`OFS_DATA: begin
						if (done_q) begin
							data_q <= pwdata[7:0];
							wcol_q <= 1'b0;
						end else
							wcol_q <= 1'b1;
					end
					`OFS_ADDR: own_q <= pwdata[7:1];
					`OFS_DIV: div_q <= pwdata[7:0];
					`OFS_IEN: ien_q <= pwdata[`IRQ_W-1:0];
					default: ;
				endcase
			end
			if (!en_q) begin
				st_q <= S_IDLE;
				{mst_q, act_q, berr_q, busy_q} <= 4'h0;
				bcnt_q <= 4'h0;
				scl_oe_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end else begin
				if (start_det)
					busy_q <= 1'b1;
				if (stop_det)
					busy_q <= 1'b0;
				// software resumes the engine by clearing job-done
				if (go) begin
					if (berr_q) begin
						if (pwdata[`B_STO]) begin
							berr_q <= 1'b0;
							sto_q <= 1'b0;
							{mst_q, act_q} <= 2'b00;
							scl_oe_q <= 1'b0;
							sda_oe_q <= 1'b0;
							st_q <= S_IDLE;
						end
					end else if (mst_q && (st_q == S_HOLD)) begin
						if (pwdata[`B_STO]) begin
							sda_oe_q <= 1'b1;
							st_q <= S_STOP1;
						end else if (pwdata[`B_STA]) begin
							sda_oe_q <= 1'b0;
							st_q <= S_RS1;
						end else begin
							sh_q <= data_q;
							ph_q <= 1'b0;
							st_q <= S_LO;
						end
					end else if (!mst_q && act_q && match_q && !first_q) begin
						sh_q <= data_q;
						if (scl_oe_q) begin
							scl_oe_q <= 1'b0;
							sda_oe_q <= txb_q & ~data_q[7];
						end
					end
				end
				// master clock and line sequencing
				case (st_q)
					S_IDLE: begin
						if (tick_q && sta_q && !busy_q && !done_q && !act_q && !berr_q) begin
							sda_oe_q <= 1'b1;
							mst_q <= 1'b1;
							rs_q <= 1'b0;
							st_q <= S_START;
						end
					end
					S_START: begin
						if (tick_q) begin
							scl_oe_q <= 1'b1;
							done_q <= 1'b1;
							ev_q[`IRQ_DONE] <= 1'b1;
							stat_q <= rs_q ? `ST_RSTART : `ST_START;
							{first_q, txb_q} <= 2'b11;
							bcnt_q <= 4'h0;
							st_q <= S_HOLD;
						end
					end
					S_HOLD: scl_oe_q <= 1'b1;
					S_LO: begin
						if (tick_q) begin
							ph_q <= ~ph_q;
							if (!ph_q)
								sda_oe_q <= drv_bit;
							else begin
								scl_oe_q <= 1'b0;
								st_q <= S_HI;
							end
						end
					end
					S_HI: begin
						if (tick_q && scl_s) begin
							scl_oe_q <= 1'b1;
							ph_q <= 1'b0;
							st_q <= (bcnt_q == `BIT_ACK) ? S_HOLD : S_LO;
						end
					end
					S_STOP1: begin
						if (tick_q) begin
							scl_oe_q <= 1'b0;
							st_q <= S_STOP2;
						end
					end
					S_STOP2: begin
						if (tick_q && scl_s) begin
							sda_oe_q <= 1'b0;
							sto_q <= 1'b0;
							{mst_q, act_q} <= 2'b00;
							st_q <= S_IDLE;
						end
					end
					S_RS1: begin
						if (tick_q) begin
							scl_oe_q <= 1'b0;
							st_q <= S_RS2;
						end
					end
					S_RS2: begin
						if (tick_q && scl_s) begin
							sda_oe_q <= 1'b1;
							rs_q <= 1'b1;
							st_q <= S_START;
						end
					end
					default: st_q <= S_IDLE;
				endcase
				// bit sampling, shared by master and slave
				if (samp) begin
					if (bcnt_q < `BIT_ACK) begin
						sh_q <= sh_n;
						bcnt_q <= bcnt_q + 4'h1;
						if (bcnt_q == `BIT_LAST) begin
							data_q <= sh_n;
							if (first_q) begin
								match_q <= (sh_q[6:0] == own_q);
								dir_q <= sda_s;
							end
							ackg_q <= acken_q & (mst_q | !first_q | (sh_q[6:0] == own_q));
						end
						if (mst_q && txb_q && sh_q[7] && !sda_s) begin
							{mst_q, txb_q} <= 2'b00;
							scl_oe_q <= 1'b0;
							sda_oe_q <= 1'b0;
							st_q <= S_IDLE;
							if (first_q && (bcnt_q != `BIT_LAST))
								arbl_q <= 1'b1;
							else begin
								act_q <= 1'b0;
								done_q <= 1'b1;
								ev_q[`IRQ_DONE] <= 1'b1;
								ev_q[`IRQ_ARB] <= 1'b1;
								stat_q <= `ST_ARB_DATA;
							end
						end
					end else begin
						bcnt_q <= 4'h0;
						first_q <= 1'b0;
						if (mst_q) begin
							done_q <= 1'b1;
							ev_q[`IRQ_DONE] <= 1'b1;
							if (first_q) begin
								txb_q <= ~dir_q;
								if (dir_q)
									stat_q <= ack ? `ST_MR_AACK : `ST_MR_ANACK;
								else
									stat_q <= ack ? `ST_MT_AACK : `ST_MT_ANACK;
							end else if (txb_q)
								stat_q <= ack ? `ST_MT_DACK : `ST_MT_DNACK;
							else
								stat_q <= ackg_q ? `ST_MR_DACK : `ST_MR_DNACK;
						end else if (first_q) begin
							arbl_q <= 1'b0;
							if (match_q && ackg_q) begin
								txb_q <= dir_q;
								done_q <= 1'b1;
								ev_q[`IRQ_DONE] <= 1'b1;
								if (dir_q)
									stat_q <= arbl_q ? `ST_ST_ARB : `ST_ST_ADDR;
								else
									stat_q <= arbl_q ? `ST_SR_ARB : `ST_SR_ADDR;
							end else begin
								act_q <= 1'b0;
								if (arbl_q) begin
									done_q <= 1'b1;
									ev_q[`IRQ_DONE] <= 1'b1;
									ev_q[`IRQ_ARB] <= 1'b1;
									stat_q <= `ST_ARB_ADDR;
								end
							end
						end else begin
							done_q <= 1'b1;
							ev_q[`IRQ_DONE] <= 1'b1;
							if (txb_q)
								stat_q <= ack ? `ST_ST_DACK : `ST_ST_DNACK;
							else
								stat_q <= ackg_q ? `ST_SR_DACK : `ST_SR_DNACK;
							if (txb_q ? !ack : !ackg_q)
								act_q <= 1'b0;
						end
					end
				end
				// slave line driving on falling clock edges
				if (drive) begin
					if ((bcnt_q == 4'h0) && !first_q && done_q) begin
						scl_oe_q <= 1'b1;
						sda_oe_q <= 1'b0;
					end else
						sda_oe_q <= drv_bit;
				end
				// START/STOP checks win over everything above
				if ((start_det || stop_det) && act_q && !gen && !legal) begin
					done_q <= 1'b1;
					ev_q[`IRQ_DONE] <= 1'b1;
					ev_q[`IRQ_BERR] <= 1'b1;
					stat_q <= `ST_BUSERR;
					berr_q <= 1'b1;
					{mst_q, act_q} <= 2'b00;
					st_q <= S_IDLE;
				end else if (start_det && !berr_q) begin
					{act_q, first_q, match_q} <= 3'b100 | 3'b010;
					bcnt_q <= 4'h0;
					if (!mst_q)
						{txb_q, arbl_q} <= 2'b00;
				end else if (stop_det && act_q) begin
					act_q <= 1'b0;
					scl_oe_q <= 1'b0;
					sda_oe_q <= 1'b0;
					if (!mst_q && match_q && !first_q) begin
						done_q <= 1'b1;
						ev_q[`IRQ_DONE] <= 1'b1;
						stat_q <= `ST_SR_STOP;
					end
				end
			end
		end
	end
endmodule // i2c_error_arbitration

/* File: src/i2c_err_arb_defs.vh */
// register offsets, field positions, status codes and reset values of the two-wire error/arbitration block
// assumes: included by bare name from the design files
`ifndef I2C_ERR_ARB_DEFS_VH
`define I2C_ERR_ARB_DEFS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_DATA 8'h08
`define OFS_ADDR 8'h0c
`define OFS_DIV 8'h10
`define OFS_IST 8'h14
`define OFS_IEN 8'h18
`define OFS_ICLR 8'h1c
// ----------------------------------------
// control register fields
// ----------------------------------------
`define B_DONE 7
`define B_ACKEN 6
`define B_STA 5
`define B_STO 4
`define B_WCOL 3
`define B_EN 2
// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define IRQ_W 3
`define IRQ_DONE 0
`define IRQ_BERR 1
`define IRQ_ARB 2
// ----------------------------------------
// status codes
// ----------------------------------------
`define ST_NOINFO 8'hf8
`define ST_BUSERR 8'h00
`define ST_START 8'h08
`define ST_RSTART 8'h10
`define ST_MT_AACK 8'h18
`define ST_MT_ANACK 8'h20
`define ST_MT_DACK 8'h28
`define ST_MT_DNACK 8'h30
`define ST_ARB_DATA 8'h38
`define ST_MR_AACK 8'h40
`define ST_MR_ANACK 8'h48
`define ST_MR_DACK 8'h50
`define ST_MR_DNACK 8'h58
`define ST_SR_ADDR 8'h60
`define ST_SR_ARB 8'h68
`define ST_SR_DACK 8'h80
`define ST_SR_DNACK 8'h88
`define ST_SR_STOP 8'ha0
`define ST_ST_ADDR 8'ha8
`define ST_ST_ARB 8'hb0
`define ST_ST_DACK 8'hb8
`define ST_ST_DNACK 8'hc0
`define ST_ARB_ADDR 8'hd0
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define DIV_RST 8'h7c
`define DIV_MIN 8'h04
`define OWN_RST 7'h7f
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_FIRST 4'h1
`endif

/* File: src/bus_line_monitor.v */
// two-stage synchronisers for the bus lines plus edge, START and STOP detection
// assumes: scl_in and sda_in are asynchronous pin levels, pulled high when released
`timescale 1ns/10ps
module bus_line_monitor (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// bus pins
	input wire scl_in,
	input wire sda_in,
	// synchronised levels and events
	output wire scl_s,
	output wire sda_s,
	output wire scl_rise,
	output wire scl_fall,
	output wire start_det,
	output wire stop_det
);
	reg scl_m_q, scl_s_q, scl_d_q;
	reg sda_m_q, sda_s_q, sda_d_q;
	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_d_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else begin
			scl_m_q <= scl_in;
			scl_s_q <= scl_m_q;
			scl_d_q <= scl_s_q;
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			sda_d_q <= sda_s_q;
		end
	end
	assign scl_s = scl_s_q;
	assign sda_s = sda_s_q;
	assign scl_rise = scl_s_q & ~scl_d_q;
	assign scl_fall = ~scl_s_q & scl_d_q;
	assign start_det = scl_s_q & scl_d_q & ~sda_s_q & sda_d_q;
	assign stop_det = scl_s_q & scl_d_q & sda_s_q & ~sda_d_q;
endmodule // bus_line_monitor

/* File: verification/i2c_error_arbitration_chk.sv */
// concurrent checks on the ports of the two-wire error/arbitration block
// assumes: bound to i2c_error_arbitration, one clock domain on pclk
`timescale 1ns/10ps
`include "i2c_err_arb_defs.vh"
module i2c_error_arbitration_chk (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// lines and interrupt
	input wire scl_in,
	input wire sda_in,
	input wire scl_out,
	input wire scl_oe,
	input wire sda_out,
	input wire sda_oe,
	input wire irq
);
	// --------
	// helper state
	// --------
	reg berr_q;
	reg ien_q;
	wire rd_stat = pready && !pwrite && paddr == `OFS_STAT;
	wire wr_ctrl = pready && pwrite && paddr == `OFS_CTRL;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			berr_q <= 1'b0;
			ien_q <= 1'b0;
		end else begin
			if (rd_stat)
				berr_q <= prdata[7:0] == `ST_BUSERR;
			if (pready && pwrite && paddr == `OFS_IEN)
				ien_q <= |pwdata[2:0];
		end
	end
	// --------
	// properties
	// --------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence recover_go;
		wr_ctrl && pwdata[`B_DONE] && pwdata[`B_STO] && berr_q;
	endsequence
	sequence lines_free;
		!scl_oe && !sda_oe;
	endsequence
	sequence master_hold;
		rd_stat && (prdata[7:0] == `ST_START || prdata[7:0] == `ST_MT_AACK || prdata[7:0] == `ST_MT_DACK);
	endsequence
	AST_APB_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_SLVERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("slave error with bad data");
	AST_PINS_LOW: assert property (!scl_out && !sda_out)
		else $error("pad level not low");
	AST_STATUS_FORM: assert property (rd_stat |-> prdata[31:8] == 24'h0 && prdata[2:0] == 3'h0)
		else $error("status out of code form");
	AST_RECOVER_RELEASE: assert property (recover_go |-> ##[1:3] lines_free ##1 lines_free [*8])
		else $error("lines not free after recovery");
	AST_MASTER_STRETCH: assert property (master_hold |-> ##[0:1] scl_oe [*2])
		else $error("clock not held low");
	AST_IRQ_MASKED: assert property (irq |-> ien_q || $past(ien_q))
		else $error("interrupt while masked");
endmodule // i2c_error_arbitration_chk
bind i2c_error_arbitration i2c_error_arbitration_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

/* File: verification/bus_partner.sv */
// far side of the bus: a slave with a fixed address plus a rival master
// assumes: wired-and lines built by the bench, pull-ups make released lines high
`timescale 1ns/10ps
module bus_partner #(
	parameter [6:0] ADDR = 7'h50,
	parameter [7:0] TX = 8'h3c
) (
	// wired levels
	input wire scl,
	input wire sda,
	// bench controls
	input wire rival,
	input wire mirror,
	input wire dut_sda_oe,
	// pull-downs of this party
	output wire scl_oe_p,
	output wire sda_oe_p,
	// last byte written to the slave
	output reg [7:0] got = 8'h00
);
	reg slv_q = 1'b0;
	reg scl_m = 1'b0;
	reg sda_m = 1'b0;
	reg act = 1'b0;
	reg first = 1'b0;
	reg hit = 1'b0;
	reg rd = 1'b0;
	reg [7:0] sh = 8'h00;
	integer bitn = 0;
	// rival pulls data low, mirror copies the other master bit for bit
	assign scl_oe_p = scl_m;
	assign sda_oe_p = slv_q | sda_m | rival | (mirror & dut_sda_oe);
	always @(negedge sda) if (scl) begin
		act = 1'b1;
		first = 1'b1;
		hit = 1'b0;
		bitn = 0;
	end
	always @(posedge sda) if (scl) begin
		act = 1'b0;
		hit = 1'b0;
		slv_q = 1'b0;
	end
	always @(posedge scl) if (act) begin
		if (bitn < 8)
			sh = {sh[6:0], sda};
		if (bitn == 8 && rd && !first && sda)
			hit = 1'b0;
		if (bitn == 8)
			first = 1'b0;
		bitn = (bitn == 8) ? 0 : bitn + 1;
	end
	// slave changes data only while the clock is low
	always @(negedge scl) if (act) begin
		#2;
		if (bitn == 8 && first)
			hit = sh[7:1] == ADDR;
		if (bitn == 8 && first)
			rd = sh[0];
		if (bitn == 8 && !first && !rd)
			got = sh;
		if (bitn == 8)
			slv_q = hit && (first || !rd);
		else
			slv_q = hit && rd && !first && !TX[7 - bitn];
	end
	// rival master at a 48 ns link period
	task m_start;
		begin
			sda_m = 1'b1;
			#24;
		end
	endtask
	task m_bit(input b);
		begin
			scl_m = 1'b1;
			#12;
			sda_m = !b;
			#12;
			scl_m = 1'b0;
			#24;
		end
	endtask
	task m_stop;
		begin
			scl_m = 1'b1;
			#12;
			sda_m = 1'b1;
			#12;
			scl_m = 1'b0;
			#12;
			sda_m = 1'b0;
			#24;
		end
	endtask
endmodule // bus_partner

/* File: verification/test_i2c_error_arbitration.sv */
// self-checking bench for the two-wire error/arbitration block
// assumes: bus_partner on the wired lines, checker bound in its own file
`timescale 1ns/10ps
`include "i2c_err_arb_defs.vh"
module test_i2c_error_arbitration;
	// --------
	// signals
	// --------
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	reg rival = 1'b0;
	reg mirror = 1'b0;
	wire [31:0] prdata;
	wire pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, scl_oe_p, sda_oe_p;
	wire [7:0] got;
	wire scl = !(scl_oe | scl_oe_p);
	wire sda = !(sda_oe | sda_oe_p);
	integer failures = 0;
	integer compares = 0;
	integer cycles = 0;
	reg [31:0] r;
	reg e;
	always #2.5 pclk = !pclk;
	i2c_error_arbitration i_i2c_error_arbitration (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	bus_partner i_bus_partner (.scl(scl), .sda(sda), .rival(rival), .mirror(mirror), .dut_sda_oe(sda_oe),
		.scl_oe_p(scl_oe_p), .sda_oe_p(sda_oe_p), .got(got));
	always @(posedge pclk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			print_verdict;
		end
	end
	// --------
	// tasks
	// --------
	task print_verdict;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got_v, input [31:0] exp_v);
		begin
			compares = compares + 1;
			if (got_v !== exp_v) begin
				failures = failures + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdchk(input [7:0] a, input [31:0] exp_v);
		begin
			apb(1'b0, a, 32'h0);
			chk(r, exp_v);
		end
	endtask
	task wait_done(input [31:0] exp_v);
		begin
			apb(1'b0, `OFS_STAT, 32'h0);
			while (r === 32'hf8)
				apb(1'b0, `OFS_STAT, 32'h0);
			chk(r, exp_v);
		end
	endtask
	task irqchk(input exp_v);
		begin
			repeat (3) @(posedge pclk);
			chk({31'h0, irq}, {31'h0, exp_v});
		end
	endtask
	// --------
	// scenarios
	// --------
	task t_reset;
		begin
			rdchk(`OFS_STAT, 32'hf8);
			rdchk(`OFS_CTRL, 32'h0);
			rdchk(`OFS_DIV, 32'h7c);
			rdchk(`OFS_ADDR, 32'hfe);
			rdchk(`OFS_IST, 32'h0);
			apb(1'b0, 8'h20, 32'h0);
			chk({31'h0, e}, 32'h1);
			wr(`OFS_DIV, 32'h4);
			wr(`OFS_CTRL, 32'h4);
			$display("test reset done");
		end
	endtask
	task t_master;
		begin
			wr(`OFS_IEN, 32'h1);
			wr(`OFS_CTRL, 32'ha4);
			wait_done(32'h08);
			irqchk(1'b1);
			wr(`OFS_IEN, 32'h0);
			irqchk(1'b0);
			wr(`OFS_ICLR, 32'h1);
			wr(`OFS_IEN, 32'h1);
			irqchk(1'b0);
			rdchk(`OFS_IST, 32'h0);
			wr(`OFS_DATA, 32'ha0);
			mirror <= 1'b1;
			wr(`OFS_CTRL, 32'h84);
			wait_done(32'h18);
			mirror <= 1'b0;
			chk({31'h0, scl}, 32'h0);
			wr(`OFS_DATA, 32'h5a);
			wr(`OFS_CTRL, 32'h84);
			rdchk(`OFS_STAT, 32'hf8);
			wr(`OFS_DATA, 32'h11);
			rdchk(`OFS_CTRL, 32'h0c);
			wait_done(32'h28);
			chk({24'h0, got}, 32'h5a);
			wr(`OFS_CTRL, 32'ha4);
			wait_done(32'h10);
			wr(`OFS_DATA, 32'ha1);
			wr(`OFS_CTRL, 32'h84);
			wait_done(32'h40);
			wr(`OFS_CTRL, 32'h84);
			wait_done(32'h58);
			rdchk(`OFS_DATA, 32'h3c);
			wr(`OFS_CTRL, 32'h94);
			repeat (200) @(posedge pclk);
			rdchk(`OFS_CTRL, 32'h04);
			$display("test master done");
		end
	endtask
	task t_loss;
		begin
			wr(`OFS_CTRL, 32'ha4);
			wait_done(32'h08);
			wr(`OFS_DATA, 32'ha0);
			wr(`OFS_CTRL, 32'h84);
			wait_done(32'h18);
			wr(`OFS_DATA, 32'hff);
			rival <= 1'b1;
			wr(`OFS_CTRL, 32'h84);
			wait_done(32'h38);
			chk({30'h0, scl_oe, sda_oe}, 32'h0);
			wr(`OFS_CTRL, 32'ha4);
			repeat (300) @(posedge pclk);
			rdchk(`OFS_STAT, 32'hf8);
			rival <= 1'b0;
			wait_done(32'h08);
			wr(`OFS_CTRL, 32'h94);
			repeat (200) @(posedge pclk);
			$display("test loss done");
		end
	endtask
	task t_buserr;
		begin
			wr(`OFS_ICLR, 32'h7);
			wr(`OFS_IEN, 32'h2);
			i_bus_partner.m_start;
			i_bus_partner.m_bit(1'b1);
			i_bus_partner.m_bit(1'b0);
			i_bus_partner.m_bit(1'b1);
			i_bus_partner.m_stop;
			@(posedge pclk);
			wait_done(32'h00);
			irqchk(1'b1);
			rdchk(`OFS_IST, 32'h3);
			wr(`OFS_CTRL, 32'h84);
			repeat (50) @(posedge pclk);
			rdchk(`OFS_STAT, 32'h00);
			wr(`OFS_CTRL, 32'hd4);
			rdchk(`OFS_CTRL, 32'h44);
			rdchk(`OFS_STAT, 32'hf8);
			chk({30'h0, scl_oe, sda_oe}, 32'h0);
			wr(`OFS_ICLR, 32'h7);
			irqchk(1'b0);
			$display("test bus error done");
		end
	endtask
	task t_slave;
		begin
			wr(`OFS_ADDR, 32'h50);
			wr(`OFS_CTRL, 32'h44);
			i_bus_partner.m_start;
			i_bus_partner.m_bit(1'b0);
			i_bus_partner.m_bit(1'b1);
			i_bus_partner.m_bit(1'b0);
			i_bus_partner.m_bit(1'b1);
			i_bus_partner.m_bit(1'b0);
			i_bus_partner.m_bit(1'b0);
			i_bus_partner.m_bit(1'b0);
			i_bus_partner.m_bit(1'b0);
			i_bus_partner.m_bit(1'b1);
			i_bus_partner.m_stop;
			@(posedge pclk);
			wait_done(32'h60);
			rdchk(`OFS_DATA, 32'h50);
			chk({31'h0, scl}, 32'h0);
			wr(`OFS_CTRL, 32'h84);
			repeat (4) @(posedge pclk);
			i_bus_partner.m_start;
			i_bus_partner.m_stop;
			@(posedge pclk);
			rdchk(`OFS_STAT, 32'hf8);
			chk({30'h0, scl_oe, sda_oe}, 32'h0);
			$display("test slave done");
		end
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_master;
		t_loss;
		t_buserr;
		t_slave;
		print_verdict;
	end
endmodule // test_i2c_error_arbitration
